// ==== logic/timer_sync_map.vh ====
`ifndef TIMER_SYNC_MAP_VH
`define TIMER_SYNC_MAP_VH

// Byte offsets of the word registers.
`define OFF_CTRL        8'h00
`define OFF_SLAVE_CFG   8'h04
`define OFF_DMA_EN      8'h08
`define OFF_STATUS      8'h0c
`define OFF_MASK        8'h10
`define OFF_COUNTER     8'h14
`define OFF_RELOAD      8'h18
`define OFF_COMPARE     8'h1c
`define OFF_CHAN_CFG    8'h20
`define OFF_DMA_CFG     8'h24
`define OFF_DMA_BUF     8'h28
`define OFF_DEBUG       8'h2c
`define OFF_PRESCALE    8'h30
`define REG_COUNT       13

// Field positions.
`define CTRL_RUN        0
`define CTRL_ONE_SHOT   3
`define CTRL_MMC_LO     4
`define SCFG_SMC_LO     0
`define SCFG_TRIGGER_SOURCE_SELECT_LO    4
`define SCFG_MSM        7
`define ST_UPDATE       0
`define ST_COMPARE      1
`define ST_TRIGGER      2
`define CCFG_MODE_LO    0
`define CCFG_FAST       3
`define CCFG_FILT_LO    4
`define DCFG_START_LO   0
`define DCFG_COUNT_LO   8

// Reset values.
`define RST_ZERO        32'h0000_0000
`define RST_RELOAD      16'hffff

// Slave mode codes.
`define SMC_RESTART     3'h4
`define SMC_PAUSE       3'h5
`define SMC_EVENT       3'h6
`define SMC_EXT0        3'h7

// Trigger source codes.
`define TRIGGER_SOURCE_SELECT_EDGE0      3'h4
`define TRIGGER_SOURCE_SELECT_FILT0      3'h5
`define TRIGGER_SOURCE_SELECT_FILT1      3'h6

// Master mode codes.
`define MMC_RESET       3'h0
`define MMC_START       3'h1
`define MMC_UPDATE      3'h2
`define MMC_CMP_PULSE   3'h3
`define MMC_CMP_REF     3'h4

// Compare output modes.
`define OCM_SET         3'h1
`define OCM_CLEAR       3'h2
`define OCM_TOGGLE      3'h3
`define OCM_LOW         3'h4
`define OCM_HIGH        3'h5
`define OCM_PWM0        3'h6
`define OCM_PWM1        3'h7

// Timing counts in clock cycles.
`define MSM_DELAY       3

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ==== logic/timer_trigger_sync.v ====
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`include "timer_sync_map.vh"
`default_nettype none
module timer_trigger_sync #(
	parameter CNT_W = 16
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  awaddr,
	input  wire        awvalid,
	output reg         awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output reg         wready,
	output reg  [1:0]  bresp,
	output reg         bvalid,
	input  wire        bready,
	input  wire [7:0]  araddr,
	input  wire        arvalid,
	output reg         arready,
	output reg  [31:0] rdata,
	output reg  [1:0]  rresp,
	output reg         rvalid,
	input  wire        rready,
	input  wire [3:0]  internal_trigger_input,
	input  wire        channel0_in,
	input  wire        channel1_in,
	input  wire        core_halted,
	output reg         trigger_output,
	output reg         output_reference,
	output reg         dma_request,
	output reg         irq
);
	reg [31:0] ctrl, slave_cfg, dma_en, status, mask, chan_cfg, dma_cfg;
	reg [31:0] debug_cfg;
	reg [CNT_W-1:0] counter, reload, compare, prescale, psc_cnt;
	reg [7:0] aw_addr, ar_addr;
	reg        aw_full, w_full;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	reg [3:0]  itr_s1, itr_s2;
	reg [1:0]  ch_s1, ch_s2, ch_filt;
	reg [3:0]  fcnt [0:1];
	reg        halt_s1, halt_s2, ch0_prev, trg_prev;
	reg [`MSM_DELAY-1:0] start_dly;
	reg        upd_ev, cmp_ev, trg_ev, rst_ev, run_prev, force_ref;
	reg [4:0]  burst_idx;
	reg        burst_again;
	reg        trg_lvl, trg_edge;
	integer    i;

	wire [2:0] slave_mode_select  = slave_cfg[`SCFG_SMC_LO+:3];
	wire [2:0] trigger_source_select = slave_cfg[`SCFG_TRIGGER_SOURCE_SELECT_LO+:3];
	wire       master_slave_sync_bit  = slave_cfg[`SCFG_MSM];
	wire       one_shot = ctrl[`CTRL_ONE_SHOT];
	wire       run  = ctrl[`CTRL_RUN];
	wire [2:0] ocm  = chan_cfg[`CCFG_MODE_LO+:3];
	wire       fast = chan_cfg[`CCFG_FAST];
	wire [3:0] filt_len = chan_cfg[`CCFG_FILT_LO+:4];
	wire [4:0] dma_start = dma_cfg[`DCFG_START_LO+:5];
	wire [4:0] dma_count = dma_cfg[`DCFG_COUNT_LO+:5];

	// Buffer accesses stand in for the register the burst points at.
	function [4:0] target;
		input [7:0] addr;
		input [4:0] start;
		input [4:0] idx;
		begin
			if (addr[6:2] == `OFF_DMA_BUF >> 2)
				target = start + idx;
			else
				target = addr[6:2];
		end
	endfunction

	function [31:0] read_reg;
		input [4:0] idx;
		begin
			case ({1'b0, idx, 2'b00})
			`OFF_CTRL:      read_reg = ctrl;
			`OFF_SLAVE_CFG: read_reg = slave_cfg;
			`OFF_DMA_EN:    read_reg = dma_en;
			`OFF_STATUS:    read_reg = status;
			`OFF_MASK:      read_reg = mask;
			`OFF_COUNTER:   read_reg = {{(32-CNT_W){1'b0}}, counter};
			`OFF_RELOAD:    read_reg = {{(32-CNT_W){1'b0}}, reload};
			`OFF_COMPARE:   read_reg = {{(32-CNT_W){1'b0}}, compare};
			`OFF_CHAN_CFG:  read_reg = chan_cfg;
			`OFF_DMA_CFG:   read_reg = dma_cfg;
			`OFF_DEBUG:     read_reg = debug_cfg;
			`OFF_PRESCALE:  read_reg = {{(32-CNT_W){1'b0}}, prescale};
			default:        read_reg = `RST_ZERO;
			endcase
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (strb[b])
					merge[b*8+:8] = data[b*8+:8];
		end
	endfunction

	function mapped;
		input [4:0] idx;
		begin
			mapped = (idx < `REG_COUNT) && (idx != (`OFF_DMA_BUF >> 2));
		end
	endfunction

	wire       do_write = aw_full && w_full && !bvalid;
	wire [4:0] w_idx    = target(aw_addr, dma_start, burst_idx);
	wire       do_read  = arvalid && arready;
	wire [4:0] r_idx    = target(araddr, dma_start, burst_idx);
	wire       wr_ok    = do_write && mapped(w_idx);
	wire [31:0] wr_val  = merge(read_reg(w_idx), w_data, w_strb);
	wire       buf_acc  = (do_write && aw_addr[6:2] == (`OFF_DMA_BUF >> 2))
		|| (do_read && araddr[6:2] == (`OFF_DMA_BUF >> 2));

	// AXI4-Lite write and read channels, one transfer of each at a time.
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready  <= 1'b0;
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= `RST_ZERO;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= `RESP_OKAY;
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= `RST_ZERO;
			rresp   <= `RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_full <= 1'b1;
				awready <= 1'b0;
				aw_addr <= awaddr;
			end else if (!aw_full && !bvalid)
				awready <= 1'b1;
			if (wvalid && wready) begin
				w_full <= 1'b1;
				wready <= 1'b0;
				w_data <= wdata;
				w_strb <= wstrb;
			end else if (!w_full && !bvalid)
				wready <= 1'b1;
			if (do_write) begin
				aw_full <= 1'b0;
				w_full  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= mapped(w_idx) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid && bready)
				bvalid <= 1'b0;
			if (do_read) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= read_reg(r_idx);
				rresp   <= mapped(r_idx) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rvalid && rready)
				rvalid <= 1'b0;
			else if (!rvalid)
				arready <= 1'b1;
		end
	end

	// Pins from outside pass two flip-flops; channels then get the filter.
	always @(posedge aclk) begin
		if (!aresetn) begin
			itr_s1  <= 4'h0;
			itr_s2  <= 4'h0;
			ch_s1   <= 2'b00;
			ch_s2   <= 2'b00;
			ch_filt <= 2'b00;
			halt_s1 <= 1'b0;
			halt_s2 <= 1'b0;
			ch0_prev <= 1'b0;
			trg_prev <= 1'b0;
			for (i = 0; i < 2; i = i + 1)
				fcnt[i] <= 4'h0;
		end else begin
			itr_s1  <= internal_trigger_input;
			itr_s2  <= itr_s1;
			ch_s1   <= {channel1_in, channel0_in};
			ch_s2   <= ch_s1;
			halt_s1 <= core_halted;
			halt_s2 <= halt_s1;
			ch0_prev <= ch_filt[0];
			trg_prev <= trg_lvl;
			for (i = 0; i < 2; i = i + 1) begin
				if (ch_s2[i] == ch_filt[i])
					fcnt[i] <= 4'h0;
				else if (fcnt[i] + 4'h1 >= filt_len) begin
					ch_filt[i] <= ch_s2[i];
					fcnt[i] <= 4'h0;
				end else
					fcnt[i] <= fcnt[i] + 4'h1;
			end
		end
	end

	always @* begin
		trg_lvl  = 1'b0;
		trg_edge = 1'b0;
		case (trigger_source_select)
		`TRIGGER_SOURCE_SELECT_EDGE0: begin
			trg_lvl  = ch_filt[0] ^ ch0_prev;
			trg_edge = trg_lvl;
		end
		`TRIGGER_SOURCE_SELECT_FILT0: begin
			trg_lvl  = ch_filt[0];
			trg_edge = trg_lvl && !trg_prev;
		end
		`TRIGGER_SOURCE_SELECT_FILT1: begin
			trg_lvl  = ch_filt[1];
			trg_edge = trg_lvl && !trg_prev;
		end
		default: begin
			trg_lvl  = itr_s2[trigger_source_select[1:0]];
			trg_edge = trg_lvl && !trg_prev;
		end
		endcase
	end

	wire freeze   = halt_s2 && debug_cfg[0];
	wire count_en = run && !freeze && (slave_mode_select != `SMC_PAUSE || trg_lvl);
	wire tick     = (slave_mode_select == `SMC_EXT0) ? trg_edge
		: (psc_cnt == prescale);
	wire step     = count_en && tick;
	wire restart  = (slave_mode_select == `SMC_RESTART) && trg_edge;
	wire start_req = trg_edge && ((slave_mode_select == `SMC_EVENT)
		|| (one_shot && slave_mode_select == `SMC_RESTART));
	wire pwm_mode = (ocm == `OCM_PWM0) || (ocm == `OCM_PWM1);
	wire [CNT_W-1:0] cnt_inc = counter + {{(CNT_W-1){1'b0}}, 1'b1};
	wire [2:0] hw_set = {trg_ev, cmp_ev, upd_ev};

	// Counter, control registers and sticky status.
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl      <= `RST_ZERO;
			slave_cfg <= `RST_ZERO;
			dma_en    <= `RST_ZERO;
			status    <= `RST_ZERO;
			mask      <= `RST_ZERO;
			chan_cfg  <= `RST_ZERO;
			dma_cfg   <= `RST_ZERO;
			debug_cfg <= `RST_ZERO;
			counter   <= {CNT_W{1'b0}};
			reload    <= `RST_RELOAD;
			compare   <= {CNT_W{1'b0}};
			prescale  <= {CNT_W{1'b0}};
			psc_cnt   <= {CNT_W{1'b0}};
			start_dly <= {`MSM_DELAY{1'b0}};
			upd_ev    <= 1'b0;
			cmp_ev    <= 1'b0;
			trg_ev    <= 1'b0;
			rst_ev    <= 1'b0;
			force_ref <= 1'b0;
		end else begin
			upd_ev <= 1'b0;
			cmp_ev <= 1'b0;
			rst_ev <= restart;
			trg_ev <= trg_edge && slave_mode_select[2];
			start_dly <= {start_dly[`MSM_DELAY-2:0], start_req && master_slave_sync_bit};
			if (start_req && !master_slave_sync_bit)
				ctrl[`CTRL_RUN] <= 1'b1;
			if (start_dly[`MSM_DELAY-1])
				ctrl[`CTRL_RUN] <= 1'b1;
			// Forcing only follows a trigger start, never a software start.
			if (start_req && fast && pwm_mode)
				force_ref <= 1'b1;
			else if (!run || counter >= compare)
				force_ref <= 1'b0;
			if (count_en && slave_mode_select != `SMC_EXT0)
				psc_cnt <= (psc_cnt == prescale) ? {CNT_W{1'b0}}
					: psc_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
			if (restart) begin
				counter <= {CNT_W{1'b0}};
				psc_cnt <= {CNT_W{1'b0}};
				upd_ev  <= 1'b1;
			end else if (step) begin
				cmp_ev <= (cnt_inc == compare);
				if (counter == reload) begin
					counter <= {CNT_W{1'b0}};
					upd_ev  <= 1'b1;
					if (one_shot)
						ctrl[`CTRL_RUN] <= 1'b0;
				end else
					counter <= cnt_inc;
			end
			// A software write of the run bit wins over the hardware start.
			if (wr_ok) begin
				case ({1'b0, w_idx, 2'b00})
				`OFF_CTRL:      ctrl <= wr_val;
				`OFF_SLAVE_CFG: slave_cfg <= wr_val;
				`OFF_DMA_EN:    dma_en <= wr_val;
				`OFF_MASK:      mask <= wr_val;
				`OFF_COUNTER:   counter <= wr_val[CNT_W-1:0];
				`OFF_RELOAD:    reload <= wr_val[CNT_W-1:0];
				`OFF_COMPARE:   compare <= wr_val[CNT_W-1:0];
				`OFF_CHAN_CFG:  chan_cfg <= wr_val;
				`OFF_DMA_CFG:   dma_cfg <= wr_val;
				`OFF_DEBUG:     debug_cfg <= wr_val;
				`OFF_PRESCALE:  prescale <= wr_val[CNT_W-1:0];
				default:        ;
				endcase
			end
			// A new event beats a simultaneous write-one-to-clear.
			if (wr_ok && w_idx == (`OFF_STATUS >> 2))
				status[2:0] <= (status[2:0] & ~(wdata_clr(w_data, w_strb)))
					| hw_set;
			else
				status[2:0] <= status[2:0] | hw_set;
		end
	end

	function [2:0] wdata_clr;
		input [31:0] data;
		input [3:0]  strb;
		begin
			wdata_clr = strb[0] ? data[2:0] : 3'b000;
		end
	endfunction

	// Compare reference, trigger output and interrupt line.
	always @(posedge aclk) begin
		if (!aresetn) begin
			output_reference <= 1'b0;
			trigger_output   <= 1'b0;
			run_prev <= 1'b0;
			irq      <= 1'b0;
		end else begin
			run_prev <= run;
			irq <= |(status[2:0] & mask[2:0]);
			if (force_ref)
				output_reference <= (ocm == `OCM_PWM1);
			else begin
				case (ocm)
				`OCM_SET:    if (cmp_ev) output_reference <= 1'b1;
				`OCM_CLEAR:  if (cmp_ev) output_reference <= 1'b0;
				`OCM_TOGGLE: if (cmp_ev)
					output_reference <= !output_reference;
				`OCM_LOW:    output_reference <= 1'b0;
				`OCM_HIGH:   output_reference <= 1'b1;
				`OCM_PWM0:   output_reference <= (counter < compare);
				`OCM_PWM1:   output_reference <= !(counter < compare);
				default:     ;
				endcase
			end
			case (ctrl[`CTRL_MMC_LO+:3])
			`MMC_RESET:     trigger_output <= rst_ev;
			`MMC_START:     trigger_output <= run && !run_prev;
			`MMC_UPDATE:    trigger_output <= upd_ev;
			`MMC_CMP_PULSE: trigger_output <= cmp_ev;
			`MMC_CMP_REF:   trigger_output <= output_reference;
			default:        trigger_output <= 1'b0;
			endcase
		end
	end

	// DMA burst engine: one request per buffer word, burst restarts on event.
	always @(posedge aclk) begin
		if (!aresetn) begin
			dma_request <= 1'b0;
			burst_idx   <= 5'h00;
			burst_again <= 1'b0;
		end else if (|(hw_set & dma_en[2:0])) begin
			dma_request <= 1'b1;
			burst_idx   <= 5'h00;
			burst_again <= 1'b0;
		end else if (buf_acc) begin
			dma_request <= 1'b0;
			if (burst_idx != dma_count) begin
				burst_idx   <= burst_idx + 5'h01;
				burst_again <= 1'b1;
			end
		end else if (burst_again) begin
			dma_request <= 1'b1;
			burst_again <= 1'b0;
		end
	end
endmodule // timer_trigger_sync
`default_nettype wire

// ==== testbench/timer_trigger_sync_sva.sv ====
`default_nettype none
module timer_trigger_sync_sva #(
	parameter CNT_W = 16
) (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic [7:0] awaddr,
	input wire logic       awvalid,
	input wire logic       awready,
	input wire logic       wready,
	input wire logic [1:0] bresp,
	input wire logic       bvalid,
	input wire logic       bready,
	input wire logic       arvalid,
	input wire logic       arready,
	input wire logic [31:0] rdata,
	input wire logic       rvalid,
	input wire logic       rready,
	input wire logic       trigger_output,
	input wire logic       dma_request,
	input wire logic       irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic buf_write;
	// Remembers whether the write in flight targets the burst buffer.
	always @(posedge aclk) begin
		if (!aresetn)
			buf_write <= 1'b0;
		else if (awvalid && awready)
			buf_write <= awaddr == 8'h28;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_write_busy: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while busy");
	a_read_busy: assert property (rvalid |-> !arready)
		else $error("read accepted while busy");
	a_b_end: assert property (bvalid && bready |=> !bvalid)
		else $error("write response repeated");
	a_dma_drop: assert property ($rose(bvalid) && buf_write |-> ##[0:1] !dma_request)
		else $error("dma request kept after buffer access");
	a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !bvalid
		&& !dma_request && !trigger_output)
		else $error("output active after reset");
endmodule // timer_trigger_sync_sva
bind timer_trigger_sync timer_trigger_sync_sva #(.CNT_W(CNT_W)) sva (
	.aclk, .aresetn, .awaddr, .awvalid, .awready, .wready, .bresp, .bvalid,
	.bready, .arvalid, .arready, .rdata, .rvalid, .rready, .trigger_output,
	.dma_request, .irq);
`default_nettype wire

// ==== testbench/peer_timer.sv ====
`default_nettype none
// Another timer in master mode, sending update pulses on a trigger line.
module peer_timer (
	input wire logic        aclk,
	output var logic [3:0]  trig
);
	timeunit 1ns;
	timeprecision 1ns;
	initial trig = 4'h0;
	// Pulses are two cycles wide so the two-stage input sampling sees them.
	task pulse(input int line, input int n);
		repeat (n) begin
			@(posedge aclk);
			trig[line] <= 1'b1;
			repeat (2) @(posedge aclk);
			trig[line] <= 1'b0;
			repeat (3) @(posedge aclk);
		end
	endtask
endmodule // peer_timer
`default_nettype wire

// ==== testbench/test_timer_trigger_sync.sv ====
`include "timer_sync_map.vh"
`default_nettype none
module test_timer_trigger_sync;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, a;
	logic [31:0] wdata = 32'h0, d, q, v, rdata;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        channel0_in = 0, channel1_in = 0, core_halted = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        trigger_output, output_reference, dma_request, irq;
	logic [1:0]  bresp, rresp, resp;
	logic [3:0]  trig;
	logic [71:0] rows [6] = '{{8'h04, 32'hffffffff, 32'hffffffff},
		{8'h10, 32'hffffffff, 32'hffffffff}, {8'h18, 32'hffffffff, 32'h0000ffff},
		{8'h24, 32'hffffffff, 32'hffffffff}, {8'h20, 32'hffffffff, 32'hffffffff},
		{8'h3c, 32'hffffffff, 32'h00000000}};
	int fail_count = 0, comparisons = 0, cyc = 0, n;
	always #20 aclk = ~aclk;
	peer_timer peer (.aclk(aclk), .trig(trig));
	timer_trigger_sync #(.CNT_W(16)) uut (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .internal_trigger_input(trig),
		.channel0_in(channel0_in), .channel1_in(channel1_in),
		.core_halted(core_halted), .trigger_output(trigger_output),
		.output_reference(output_reference), .dma_request(dma_request),
		.irq(irq));
	task test_done;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] ad, input logic [31:0] dt);
		@(posedge aclk);
		awaddr <= ad;
		wdata <= dt;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task rd(input logic [7:0] ad, output logic [31:0] dt);
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		dt = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task fire(input int s);
		if (s < 4) peer.pulse(s, 1);
		else begin
			@(posedge aclk);
			channel0_in <= s != 6;
			channel1_in <= s == 6;
			repeat (4) @(posedge aclk);
			channel0_in <= 1'b0;
			channel1_in <= 1'b0;
			repeat (4) @(posedge aclk);
		end
	endtask
	task wait_dma;
		do @(posedge aclk); while (!dma_request);
	endtask
	// A hang anywhere ends in the closing report rather than running on.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			test_done;
		end
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h18, v);
		chk(v, 32'h0000ffff);
		for (int i = 0; i < 6; i++) begin
			{a, d, q} = rows[i];
			wr(a, d);
			chk(resp, a > 8'h30 ? `RESP_SLVERR : `RESP_OKAY);
			rd(a, v);
			chk(v, q);
		end
		wr(8'h04, 32'h0);
		wr(8'h18, 32'h3);
		wr(8'h00, 32'h21);
		do @(posedge aclk); while (!trigger_output);
		n = 0;
		do begin @(posedge aclk); n++; end while (!trigger_output);
		chk(n, 4);
		chk(irq, 1'b1);
		wr(8'h00, 32'h0);
		wr(8'h0c, 32'h7);
		wr(8'h10, 32'h0);
		chk(irq, 1'b0);
		wr(8'h00, 32'h1);
		repeat (10) @(posedge aclk);
		chk(irq, 1'b0);
		// A two-sample filter still passes the four-cycle channel pulses.
		wr(8'h20, 32'h20);
		for (int s = 0; s < 7; s++) begin
			wr(8'h00, 32'h0);
			wr(8'h04, {25'h0, s[2:0], 4'h6});
			peer.pulse(s == 0 ? 1 : 0, 1);
			rd(8'h00, v);
			chk(v, 32'h0);
			fire(s);
			rd(8'h00, v);
			chk(v, 32'h1);
		end
		wr(8'h00, 32'h0);
		wr(8'h18, 32'hffff);
		wr(8'h14, 32'h0);
		wr(8'h04, 32'h7);
		wr(8'h2c, 32'h1);
		wr(8'h00, 32'h1);
		peer.pulse(0, 5);
		rd(8'h14, v);
		chk(v, 32'h5);
		core_halted <= 1'b1;
		peer.pulse(0, 3);
		rd(8'h14, v);
		chk(v, 32'h5);
		core_halted <= 1'b0;
		peer.pulse(0, 1);
		wr(8'h00, 32'h0);
		peer.pulse(0, 2);
		rd(8'h14, v);
		chk(v, 32'h6);
		wr(8'h04, 32'h0);
		wr(8'h18, 32'd40);
		for (int k = 0; k < 2; k++) begin
			if (k == 0) wr(8'h00, 32'h9);
			else begin
				wr(8'h04, 32'h6);
				wr(8'h00, 32'h8);
				peer.pulse(0, 1);
			end
			rd(8'h00, v);
			chk(v, 32'h9);
			repeat (60) @(posedge aclk);
			rd(8'h00, v);
			chk(v, 32'h8);
			rd(8'h14, v);
			chk(v, 32'h0);
		end
		wr(8'h04, 32'h0);
		wr(8'h18, 32'h3);
		wr(8'h08, 32'h1);
		wr(8'h24, 32'h0107);
		wr(8'h00, 32'h9);
		wait_dma;
		wr(8'h28, 32'h1234);
		wr(8'h00, 32'h9);
		// Let the new update event restart the burst before the next access.
		repeat (8) @(posedge aclk);
		wait_dma;
		wr(8'h28, 32'h4321);
		wait_dma;
		wr(8'h28, 32'h5a);
		repeat (4) @(posedge aclk);
		chk(dma_request, 1'b0);
		rd(8'h1c, v);
		chk(v, 32'h4321);
		rd(8'h20, v);
		chk(v, 32'h5a);
		wr(8'h1c, 32'd30);
		wr(8'h18, 32'd40);
		wr(8'h20, 32'hf);
		wr(8'h04, 32'h6);
		wr(8'h00, 32'h8);
		peer.pulse(0, 1);
		chk(output_reference, 1'b1);
		repeat (60) @(posedge aclk);
		wr(8'h00, 32'h9);
		chk(output_reference, 1'b0);
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h86);
		peer.pulse(0, 1);
		rd(8'h00, v);
		chk(v, 32'h1);
		test_done;
	end
endmodule // test_timer_trigger_sync
`default_nettype wire
